// ### hw/fcdp_defines.svh
`ifndef FCDP_DEFINES_SVH
`define FCDP_DEFINES_SVH

// ----------------------------------------
// Register addresses (index into the data memory window of this block)
// ----------------------------------------
`define FCDP_ADDR_CH0_HIGH 3'h0
`define FCDP_ADDR_CH0_LOW 3'h1
`define FCDP_ADDR_CH1_HIGH 3'h2
`define FCDP_ADDR_CH1_LOW 3'h3
`define FCDP_ADDR_CH2_HIGH 3'h4
`define FCDP_ADDR_CH2_LOW 3'h5
`define FCDP_ADDR_CH3_HIGH 3'h6
`define FCDP_ADDR_CH3_LOW 3'h7

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FCDP_LOW_SEL_BIT 0
`define FCDP_LOW_FINE_MSB 7
`define FCDP_LOW_FINE_LSB 4
`define FCDP_LOW_RD_MASK 8'hf1
`define FCDP_HIGH_RST 8'h00
`define FCDP_LOW_RST 8'h00

// ----------------------------------------
// Timing counts in system clocks
// ----------------------------------------
`define FCDP_FULL_CYCLE_CLKS 4096
`define FCDP_SUB_CYCLE_CLKS 256
`define FCDP_SUB_CYCLES 16

`endif

// ### hw/fcdp_pkg.sv
package fcdp_pkg;

  typedef logic [11:0] fcdp_duty_t;
  typedef logic [7:0] fcdp_byte_t;

  // Phase of the shared sequencer within one full cycle
  typedef struct packed {
    logic [3:0] sub_idx;
    logic [7:0] tick;
  } fcdp_phase_s;

endpackage

// ### hw/fcdp_seq_if.sv
`timescale 1ns/100ps
interface fcdp_seq_if;
  import fcdp_pkg::*;

  fcdp_phase_s phase;
  logic cycle_start;

  modport src (output phase, output cycle_start);
  modport dst (input phase, input cycle_start);
endinterface

// ### hw/fcdp_seq.sv
`timescale 1ns/100ps
`include "fcdp_defines.svh"

// ----------------------------------------
// Shared 12-bit cycle sequencer
// ----------------------------------------
module fcdp_seq
  import fcdp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  fcdp_seq_if.src seq
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;

  // Free-running on the system clock, wraps every full cycle
  assign cnt_d = cnt_q + 12'h001;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Upper nibble numbers the sub-cycle, low byte counts inside it
  assign seq.phase = fcdp_phase_s'(cnt_q);
  // Flag sits on the last count so the duty copy is already in place at count 0;
  // flagging count 0 itself would let its first tick still run on the old duty
  assign seq.cycle_start = (cnt_q == 12'hfff);
endmodule

// ### hw/fcdp_chan.sv
`timescale 1ns/100ps
`include "fcdp_defines.svh"

// ----------------------------------------
// One modulator channel
// ----------------------------------------
module fcdp_chan
  import fcdp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire fcdp_duty_t duty_i,
  fcdp_seq_if.dst seq,
  output logic wave_o
);

  fcdp_duty_t act_q;
  logic [7:0] coarse;
  logic [3:0] fine;
  logic [8:0] high_len;
  logic wave_d;
  logic wave_q;

  // Latch duty only at the cycle boundary so a cycle never mixes values
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q <= 12'h000;
    end else if (seq.cycle_start) begin
      act_q <= duty_i;
    end
  end

  assign coarse = act_q[11:4];
  assign fine = act_q[3:0];
  // Extra clock in the first sub-cycles below the fine value
  assign high_len = {1'b0, coarse} + {8'h00, (seq.phase.sub_idx < fine)};
  // High first, then low for the rest of the 256 clocks
  assign wave_d = ({1'b0, seq.phase.tick} < high_len);

  // Registered so the output is glitch free; one clock of latency
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  assign wave_o = wave_q;
endmodule

// ### hw/fcdp_top.sv
`timescale 1ns/100ps
`include "fcdp_defines.svh"

// Function
// - Each channel holds a 12-bit duty split over a high/low register pair.
// - Channel counters advance on the system clock only, no prescaler.
// - One full output cycle lasts exactly 4096 system clocks.
// - Full cycle holds sixteen 256-clock sub-cycles numbered 0 to 15.
// - Duty bits 11..4 are coarse duty, bits 3..0 are fine duty.
// - Sub-cycle i is high coarse+1 clocks if i below fine, else coarse.
// - Hardware sequences the sub-cycles; software only writes the duty.
// - Low register bit 0 routes the modulator to the pin when set.
// - Selected and output: port data 1 passes waveform, 0 forces low.
// - Selected but direction input: pin stays input, no waveform driven.
// - Each channel shares one dedicated port pin with general I/O.
// - Registers reset to zero; low register bits 3..1 read zero.
module fcdp_top
  import fcdp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [3:0] port_dir_i,
  input wire logic [3:0] port_data_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe_o,
  output logic [3:0] pin_pwm_owned_o
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  fcdp_byte_t high_q [4];
  fcdp_byte_t low_q [4];
  logic [3:0] wave;
  logic [3:0] pin_d;
  logic [3:0] oe_d;
  logic [3:0] sel;
  logic [7:0] rdata_d;
  logic [7:0] rd_high;
  logic [7:0] rd_low;
  logic [1:0] rd_ch;

  fcdp_seq_if seq_bus ();

  // Shared counter; all channels stay phase aligned on the system clock
  fcdp_seq u_seq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .seq(seq_bus)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      logic wr_high;
      logic wr_low;

      // Byte address: even is the high register, odd the low one
      assign wr_high = reg_wr_i && (reg_addr_i == 3'(2 * g));
      assign wr_low = reg_wr_i && (reg_addr_i == 3'(2 * g + 1));

      // Unimplemented low bits are never stored, so they read zero
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          high_q[g] <= `FCDP_HIGH_RST;
          low_q[g] <= `FCDP_LOW_RST;
        end else begin
          if (wr_high) begin
            high_q[g] <= reg_wdata_i;
          end
          if (wr_low) begin
            low_q[g] <= reg_wdata_i & `FCDP_LOW_RD_MASK;
          end
        end
      end

      assign sel[g] = low_q[g][`FCDP_LOW_SEL_BIT];

      // Coarse from the high byte, fine from the top nibble of the low byte
      fcdp_chan u_chan (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .duty_i({high_q[g], low_q[g][`FCDP_LOW_FINE_MSB:`FCDP_LOW_FINE_LSB]}),
        .seq(seq_bus),
        .wave_o(wave[g])
      );

      // Direction 0 means output; data bit gates the waveform
      assign oe_d[g] = sel[g] && !port_dir_i[g];
      assign pin_d[g] = oe_d[g] && port_data_i[g] && wave[g];
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  assign rd_ch = reg_addr_i[2:1];
  assign rd_high = high_q[rd_ch];
  assign rd_low = low_q[rd_ch];
  assign rdata_d = reg_addr_i[0] ? rd_low : rd_high;

  // Outputs registered; read data lags the address by one clock
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      pin_o <= 4'h0;
      pin_oe_o <= 4'h0;
      pin_pwm_owned_o <= 4'h0;
    end else begin
      reg_rdata_o <= rdata_d;
      pin_o <= pin_d;
      pin_oe_o <= oe_d;
      pin_pwm_owned_o <= oe_d;
    end
  end
endmodule

// ### verif/fcdp_load_model.sv
`timescale 1ns/100ps
// ---
// Pin load
// ---
module fcdp_load_model (
  input wire logic [3:0] drv_i,
  input wire logic [3:0] oe_i,
  output logic [3:0] pad_o
);
  // A released pin rises through its pull-high, so it never keeps the last level
  assign pad_o = drv_i & oe_i | ~oe_i;
endmodule

// ### verif/fcdp_top_monitor.sv
`timescale 1ns/100ps
// ---
// Port checker
// ---
module fcdp_top_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0] port_dir_i,
  input wire logic [3:0] port_data_i,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe_o,
  input wire logic [3:0] pin_pwm_owned_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Reads trail the address by one edge; pin gating may trail its inputs by two
  AST_RST_CLEAR: assert property ($fell(rst_i) |-> {reg_rdata_o, pin_oe_o} == 12'h000)
    else $error("reset");
  AST_LOW_PAD: assert property ($past(reg_addr_i[0]) |-> reg_rdata_o[3:1] == 3'h0)
    else $error("pad");
  AST_WR_RD: assert property ((reg_wr_i ##1 !reg_wr_i && $stable(reg_addr_i)) |=>
    reg_rdata_o == ($past(reg_wdata_i, 2) & ($past(reg_addr_i[0]) ? 8'hf1 : 8'hff)))
    else $error("readback");
  AST_HOLD: assert property (
    (!reg_wr_i && $stable(reg_addr_i)) [*3] |-> $stable(reg_rdata_o)) else $error("hold");
  AST_DIR_IN: assert property (
    (pin_oe_o & port_dir_i & $past(port_dir_i) & $past(port_dir_i, 2)) == 4'h0)
    else $error("input driven");
  AST_DATA_LOW: assert property (
    (pin_o & ~(port_data_i | $past(port_data_i) | $past(port_data_i, 2))) == 4'h0)
    else $error("not forced low");
  AST_OE_ZERO: assert property ((pin_o & ~pin_oe_o) == 4'h0) else $error("undriven");
  AST_OWNED: assert property (pin_pwm_owned_o == pin_oe_o) else $error("owner");
endmodule
bind fcdp_top fcdp_top_monitor i_fcdp_top_monitor (.mclk_i, .rst_i, .reg_addr_i, .reg_wr_i,
  .reg_wdata_i, .reg_rdata_o, .port_dir_i, .port_data_i, .pin_o, .pin_oe_o, .pin_pwm_owned_o);

// ### verif/fcdp_top_bench.sv
`timescale 1ns/100ps
module fcdp_top_bench;
  logic mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, rd_v = 1'b0, meas_v = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, lo;
  logic [3:0] port_dir_i = 4'h0, port_data_i = 4'hf, pin_o, pin_oe_o, pin_pwm_owned_o, pad, sel;
  logic [12:0] exp_q[$], hi[4];
  logic [11:0] duty[4];
  int error_cnt = 0, samples_checked = 0, cyc = 0, n = 0;
  fcdp_top i_fcdp_top (.mclk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .port_dir_i, .port_data_i, .pin_o, .pin_oe_o, .pin_pwm_owned_o);
  fcdp_load_model i_fcdp_load_model (.drv_i(pin_o), .oe_i(pin_oe_o), .pad_o(pad));
  // Clock
  initial forever #10 mclk_i = ~mclk_i;
  task automatic check(string nm, logic [12:0] seen, logic [12:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One optional write, then a readback of the same register
  task automatic acc(logic w, logic [2:0] a, logic [7:0] d, logic [7:0] e);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
    rd_v = 1'b1;
    exp_q.push_back({5'h00, e});
    @(negedge mclk_i);
    rd_v = 1'b0;
  endtask
  // Watcher: a full 4096-clock window sums to the duty whatever its phase
  always @(posedge mclk_i) begin
    if (++cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
    #1;
    if (rd_v) check("rdata", {5'h00, reg_rdata_o}, exp_q.pop_front());
    n = meas_v ? n + 1 : 0;
    for (int c = 0; c < 4; c++) begin
      hi[c] = (n == 1 ? 13'h0000 : hi[c]) + 13'(pad[c]);
      if (n == 4096) check("pad_high", hi[c], exp_q.pop_front());
    end
  end
  // Stimulus
  initial begin
    void'($urandom(98));
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    for (int a = 0; a < 8; a++) acc(1'b0, 3'(a), 8'h00, 8'h00);
    for (int r = 0; r < 4; r++) begin
      sel = r == 0 ? 4'hf : 4'($urandom);
      for (int c = 0; c < 4; c++) begin
        duty[c] = 12'($urandom);
        lo = {duty[c][3:0], 3'($urandom), sel[c]};
        acc(1'b1, 3'(2 * c), duty[c][11:4], duty[c][11:4]);
        acc(1'b1, 3'(2 * c + 1), lo, lo & 8'hf1);
      end
      port_dir_i = r == 0 ? 4'h0 : 4'($urandom);
      port_data_i = r == 0 ? 4'hf : 4'($urandom);
      // Longer than one cycle, so the new duty is in force before the window
      repeat (4200) @(negedge mclk_i);
      for (int c = 0; c < 4; c++) exp_q.push_back(!sel[c] || port_dir_i[c] ? 13'h1000 :
        port_data_i[c] ? {1'b0, duty[c]} : 13'h0000);
      meas_v = 1'b1;
      repeat (4100) @(negedge mclk_i);
      meas_v = 1'b0;
    end
    tally_and_finish();
  end
endmodule
